// ### include/wdog_pkg.sv
// Behaviour
// - once enabled the counter runs toward the selected timeout with no further action
// - reaching the timeout without a restart raises the device reset request
// - eleven timeout settings, from the shortest 8 ticks up to 8192 ticks
// - the counter advances only on the one kilohertz low power tick
// - a restart instruction from the core clears the count to zero
// - window mode defines an open restart slot inside the total timeout
// - in window mode an early restart or a late missing one resets the device
// - counting continues in active mode and every sleep mode when enabled
// - counting steps on clk_i edges while the tick is high, so loss of the system clock stops it and no reset follows
// - settings change only after the protection key opens a short write window
// - with the lock fuse programmed every settings change is ignored
package wdog_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int CNT_W = 14;
  localparam int CODE_W = 4;
  localparam int KEYWIN_W = 3;

  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] PROT_OFS = 4'h8;

  localparam logic [DATA_W-1:0] PROT_KEY = 32'h0000_00a5;
  localparam logic [KEYWIN_W-1:0] PROT_WINDOW_CYCLES = 3'h4;

  // period code n selects 2^(n+3) ticks: 8 ms up to 8 s at 1 kHz
  localparam logic [CODE_W-1:0] PER_MAX = 4'ha;
  localparam int PER_BASE_SHIFT = 3;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_WIN_BIT = 1;
  localparam int CTRL_PER_LSB = 4;
  localparam int CTRL_WPER_LSB = 8;

  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_PREST_BIT = 16;
  localparam int STAT_PCFG_BIT = 17;
  localparam int STAT_OPEN_BIT = 18;
  localparam int STAT_EARLY_BIT = 20;
  localparam int STAT_LATE_BIT = 21;

  localparam logic [CODE_W-1:0] RST_PER = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;

  typedef enum logic {
    PROT_LOCKED = 1'b0,
    PROT_OPEN = 1'b1
  } prot_state_type;

  typedef struct packed {
    logic enable;
    logic win_en;
    logic [CODE_W-1:0] per;
    logic [CODE_W-1:0] wper;
  } cfg_type;

  typedef struct packed {
    cfg_type cfg;
    cfg_type pend_cfg;
    logic pend_cfg_valid;
    logic pend_restart;
    logic [CNT_W-1:0] cnt;
    prot_state_type prot;
    logic [KEYWIN_W-1:0] key_left;
    logic rst_req;
    logic early_err;
    logic late_err;
    logic [DATA_W-1:0] rdata;
  } state_type;

endpackage

// ### hw/windowed_watchdog_timer.sv
`timescale 1ns/1ps
module windowed_watchdog_timer #(
  parameter int ADDR_W = wdog_pkg::ADDR_W,
  parameter int DATA_W = wdog_pkg::DATA_W
) (
  input wire logic clk_i, // system clock, 250 MHz
  input wire logic srst_i, // synchronous reset, active high
  input wire logic tick_i, // one-cycle pulse per 1 kHz low power tick
  input wire logic restart_i, // one-cycle pulse: restart instruction executed
  input wire logic lock_fuse_i, // level: settings lock fuse programmed
  input wire logic [ADDR_W-1:0] addr_i, // register address
  input wire logic [DATA_W-1:0] wdata_i, // register write data
  input wire logic we_i, // write strobe
  input wire logic re_i, // read strobe
  output logic [DATA_W-1:0] rdata_o, // read data, valid the cycle after re_i
  output logic reset_req_o // device reset request, held until srst_i
);

  wdog_pkg::state_type q;
  wdog_pkg::state_type d;

  function automatic logic [wdog_pkg::CNT_W-1:0] period_ticks(
    input logic [wdog_pkg::CODE_W-1:0] code
  );
    period_ticks = wdog_pkg::CNT_ONE << (int'(code) + wdog_pkg::PER_BASE_SHIFT);
  endfunction

  function automatic logic cfg_legal(input wdog_pkg::cfg_type c);
    logic ok;
    ok = (c.per <= wdog_pkg::PER_MAX) && (c.wper <= wdog_pkg::PER_MAX);
    // the open slot must lie inside the total period
    if (c.win_en && (c.wper >= c.per)) begin
      ok = 1'b0;
    end
    cfg_legal = ok;
  endfunction

  wdog_pkg::cfg_type wr_cfg;
  logic ctrl_wr;
  logic key_wr;
  logic [wdog_pkg::CNT_W-1:0] cnt_inc;
  logic [wdog_pkg::CNT_W-1:0] per_lim;
  logic [wdog_pkg::CNT_W-1:0] wper_lim;

  always_comb begin
    wr_cfg.enable = wdata_i[wdog_pkg::CTRL_EN_BIT];
    wr_cfg.win_en = wdata_i[wdog_pkg::CTRL_WIN_BIT];
    wr_cfg.per = wdata_i[wdog_pkg::CTRL_PER_LSB +: wdog_pkg::CODE_W];
    wr_cfg.wper = wdata_i[wdog_pkg::CTRL_WPER_LSB +: wdog_pkg::CODE_W];
    ctrl_wr = we_i && (addr_i == wdog_pkg::CTRL_OFS);
    key_wr = we_i && (addr_i == wdog_pkg::PROT_OFS) && (wdata_i == wdog_pkg::PROT_KEY);
    cnt_inc = q.cnt + wdog_pkg::CNT_ONE;
    per_lim = period_ticks(q.cfg.per);
    wper_lim = period_ticks(q.cfg.wper);
  end

  always_comb begin
    d = q;

    // protection window: key opens it for a few cycles, any control write closes it
    unique case (q.prot)
      wdog_pkg::PROT_LOCKED: begin
        if (key_wr && !lock_fuse_i) begin
          d.prot = wdog_pkg::PROT_OPEN;
          d.key_left = wdog_pkg::PROT_WINDOW_CYCLES;
        end
      end
      wdog_pkg::PROT_OPEN: begin
        d.key_left = q.key_left - 3'h1;
        if (ctrl_wr || (q.key_left == 3'h1)) begin
          d.prot = wdog_pkg::PROT_LOCKED;
          d.key_left = 3'h0;
        end
      end
    endcase

    // a new setting waits for the next tick, a late write on a tick is not lost
    if (tick_i) begin
      d.pend_cfg_valid = 1'b0;
      d.pend_restart = 1'b0;
    end
    if (ctrl_wr && (q.prot == wdog_pkg::PROT_OPEN) && !lock_fuse_i
        && cfg_legal(wr_cfg)) begin
      d.pend_cfg = wr_cfg;
      d.pend_cfg_valid = 1'b1;
    end
    if (restart_i) begin
      d.pend_restart = 1'b1;
    end

    // counting advances only on a tick sampled on the clk_i edge, never on sleep state
    if (tick_i) begin
      if (q.pend_cfg_valid) begin
        d.cfg = q.pend_cfg;
        d.cnt = wdog_pkg::CNT_ZERO;
      end else if (q.pend_restart) begin
        if (q.cfg.enable && q.cfg.win_en && (q.cnt < wper_lim)) begin
          d.rst_req = 1'b1;
          d.early_err = 1'b1;
        end
        d.cnt = wdog_pkg::CNT_ZERO;
      end else if (q.cfg.enable && !q.rst_req) begin
        d.cnt = cnt_inc;
        if (cnt_inc >= per_lim) begin
          d.rst_req = 1'b1;
          d.late_err = 1'b1;
        end
      end
    end

    d.rdata = '0;
    if (re_i) begin
      unique case (addr_i)
        wdog_pkg::CTRL_OFS: begin
          d.rdata[wdog_pkg::CTRL_EN_BIT] = q.cfg.enable;
          d.rdata[wdog_pkg::CTRL_WIN_BIT] = q.cfg.win_en;
          d.rdata[wdog_pkg::CTRL_PER_LSB +: wdog_pkg::CODE_W] = q.cfg.per;
          d.rdata[wdog_pkg::CTRL_WPER_LSB +: wdog_pkg::CODE_W] = q.cfg.wper;
        end
        wdog_pkg::STATUS_OFS: begin
          d.rdata[wdog_pkg::STAT_CNT_LSB +: wdog_pkg::CNT_W] = q.cnt;
          d.rdata[wdog_pkg::STAT_PREST_BIT] = q.pend_restart;
          d.rdata[wdog_pkg::STAT_PCFG_BIT] = q.pend_cfg_valid;
          d.rdata[wdog_pkg::STAT_OPEN_BIT] = (q.prot == wdog_pkg::PROT_OPEN);
          d.rdata[wdog_pkg::STAT_EARLY_BIT] = q.early_err;
          d.rdata[wdog_pkg::STAT_LATE_BIT] = q.late_err;
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= '0;
      q.cfg.per <= wdog_pkg::RST_PER;
      q.prot <= wdog_pkg::PROT_LOCKED;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign reset_req_o = q.rst_req;

  AST_TIMEOUT_RESET: assert property (@(posedge clk_i) disable iff (srst_i)
    tick_i && q.cfg.enable && !q.pend_cfg_valid && !q.pend_restart && !q.rst_req
    && (cnt_inc == per_lim) |=> reset_req_o && q.late_err)
    else $error("timeout did not raise reset request");

  AST_COUNT_RUNS: assert property (@(posedge clk_i) disable iff (srst_i)
    tick_i && q.cfg.enable && !q.pend_cfg_valid && !q.pend_restart && !q.rst_req
    |=> q.cnt == $past(cnt_inc))
    else $error("enabled counter did not advance on tick");

  AST_RESTART_CLEARS: assert property (@(posedge clk_i) disable iff (srst_i)
    tick_i && q.pend_restart && !q.pend_cfg_valid |=> q.cnt == wdog_pkg::CNT_ZERO)
    else $error("restart did not clear the count at the next tick");

  AST_EARLY_RESET: assert property (@(posedge clk_i) disable iff (srst_i)
    tick_i && q.pend_restart && !q.pend_cfg_valid && q.cfg.enable && q.cfg.win_en
    && (q.cnt < wper_lim) |=> reset_req_o && q.early_err)
    else $error("early restart in window mode did not reset");

  AST_OPEN_RESTART_OK: assert property (@(posedge clk_i) disable iff (srst_i)
    tick_i && q.pend_restart && !q.pend_cfg_valid && q.cfg.win_en && !q.rst_req
    && (q.cnt >= wper_lim) |=> !reset_req_o)
    else $error("restart inside the open slot caused a reset");

  AST_SLOT_INSIDE: assert property (@(posedge clk_i) disable iff (srst_i)
    q.cfg.win_en |-> (q.cfg.wper < q.cfg.per))
    else $error("window slot not inside timeout period");

  AST_PERIOD_LEGAL: assert property (@(posedge clk_i) disable iff (srst_i)
    q.cfg.per <= wdog_pkg::PER_MAX)
    else $error("period code out of range");

  AST_TICK_ONLY: assert property (@(posedge clk_i) disable iff (srst_i)
    !tick_i |=> $stable(q.cnt) && $stable(q.cfg))
    else $error("count or settings changed without a tick");

  AST_NEED_KEY: assert property (@(posedge clk_i) disable iff (srst_i)
    ctrl_wr && (q.prot == wdog_pkg::PROT_LOCKED) && !q.pend_cfg_valid
    |=> !q.pend_cfg_valid)
    else $error("settings accepted without protection key");

  AST_FUSE_LOCK: assert property (@(posedge clk_i) disable iff (srst_i)
    lock_fuse_i && !q.pend_cfg_valid |=> !q.pend_cfg_valid)
    else $error("settings change accepted with lock fuse programmed");

  AST_RESET_STICKY: assert property (@(posedge clk_i) disable iff (srst_i)
    reset_req_o |=> reset_req_o)
    else $error("reset request dropped before system reset");

  AST_PENDING_HELD: assert property (@(posedge clk_i) disable iff (srst_i)
    restart_i |=> q.pend_restart)
    else $error("restart request lost before the next tick");

  AST_RESTART_WAITS: assert property (@(posedge clk_i) disable iff (srst_i)
    q.pend_restart && !tick_i |=> q.pend_restart)
    else $error("pending restart dropped between ticks");

  AST_CFG_WAITS: assert property (@(posedge clk_i) disable iff (srst_i)
    q.pend_cfg_valid && !tick_i |=> q.pend_cfg_valid)
    else $error("pending settings dropped between ticks");

  AST_TICK_DRAINS: assert property (@(posedge clk_i) disable iff (srst_i)
    tick_i && !ctrl_wr && !restart_i |=> !q.pend_cfg_valid && !q.pend_restart)
    else $error("pending items survived a tick");

  AST_CFG_APPLIED: assert property (@(posedge clk_i) disable iff (srst_i)
    tick_i && q.pend_cfg_valid
    |=> q.cfg == $past(q.pend_cfg) && q.cnt == wdog_pkg::CNT_ZERO)
    else $error("pending settings not applied at the tick");

  AST_PEND_LEGAL: assert property (@(posedge clk_i) disable iff (srst_i)
    q.pend_cfg_valid |-> cfg_legal(q.pend_cfg))
    else $error("illegal settings waiting to be applied");

  AST_WPER_LEGAL: assert property (@(posedge clk_i) disable iff (srst_i)
    q.cfg.wper <= wdog_pkg::PER_MAX)
    else $error("window code out of range");

  AST_ILLEGAL_DROPPED: assert property (@(posedge clk_i) disable iff (srst_i)
    ctrl_wr && !cfg_legal(wr_cfg) && !q.pend_cfg_valid |=> !q.pend_cfg_valid)
    else $error("illegal settings write was accepted");

  // protection window: key, short open slot, then closed again
  AST_KEY_OPENS: assert property (@(posedge clk_i) disable iff (srst_i)
    key_wr && !lock_fuse_i && (q.prot == wdog_pkg::PROT_LOCKED)
    |=> (q.prot == wdog_pkg::PROT_OPEN) && (q.key_left == wdog_pkg::PROT_WINDOW_CYCLES))
    else $error("protection key did not open the write window");

  AST_WINDOW_EXPIRES: assert property (@(posedge clk_i) disable iff (srst_i)
    (q.prot == wdog_pkg::PROT_OPEN) && (q.key_left == 3'h1)
    |=> q.prot == wdog_pkg::PROT_LOCKED)
    else $error("write window stayed open too long");

  AST_CTRL_CLOSES: assert property (@(posedge clk_i) disable iff (srst_i)
    ctrl_wr && (q.prot == wdog_pkg::PROT_OPEN) |=> q.prot == wdog_pkg::PROT_LOCKED)
    else $error("settings write left the window open");

  AST_CFG_TAKEN: assert property (@(posedge clk_i) disable iff (srst_i)
    ctrl_wr && (q.prot == wdog_pkg::PROT_OPEN) && !lock_fuse_i && cfg_legal(wr_cfg)
    |=> q.pend_cfg_valid && (q.pend_cfg == $past(wr_cfg)))
    else $error("legal protected settings write was lost");

  AST_FUSE_NO_OPEN: assert property (@(posedge clk_i) disable iff (srst_i)
    lock_fuse_i && (q.prot == wdog_pkg::PROT_LOCKED) |=> q.prot == wdog_pkg::PROT_LOCKED)
    else $error("write window opened with lock fuse programmed");

  // counting and reset request
  AST_DISABLED_HOLD: assert property (@(posedge clk_i) disable iff (srst_i)
    tick_i && !q.cfg.enable && !q.pend_cfg_valid && !q.pend_restart
    |=> $stable(q.cnt) && $stable(reset_req_o))
    else $error("disabled counter moved on a tick");

  AST_BELOW_PERIOD: assert property (@(posedge clk_i) disable iff (srst_i)
    q.cfg.enable && !q.rst_req |-> q.cnt < per_lim)
    else $error("count passed the period without a reset request");

  AST_FROZEN: assert property (@(posedge clk_i) disable iff (srst_i)
    q.rst_req && !q.pend_cfg_valid && !q.pend_restart |=> $stable(q.cnt))
    else $error("count moved after the reset request");

  AST_CAUSE_KNOWN: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(reset_req_o) |-> q.early_err || q.late_err)
    else $error("reset request raised with no cause flag");

  AST_RISE_ON_TICK: assert property (@(posedge clk_i) disable iff (srst_i)
    !tick_i && !reset_req_o |=> !reset_req_o)
    else $error("reset request raised between ticks");

  AST_NORMAL_ANY_TIME: assert property (@(posedge clk_i) disable iff (srst_i)
    tick_i && q.pend_restart && !q.cfg.win_en && !q.rst_req |=> !reset_req_o)
    else $error("restart in normal mode caused a reset");

  AST_EARLY_STICKY: assert property (@(posedge clk_i) disable iff (srst_i)
    q.early_err |=> q.early_err)
    else $error("early restart cause cleared before system reset");

  AST_LATE_STICKY: assert property (@(posedge clk_i) disable iff (srst_i)
    q.late_err |=> q.late_err)
    else $error("timeout cause cleared before system reset");

  // read port: data stand one cycle after the strobe and are zero otherwise
  AST_RDATA_IDLE: assert property (@(posedge clk_i) disable iff (srst_i)
    !re_i |=> rdata_o == '0)
    else $error("read data not zero without a read strobe");

  AST_RDATA_UNMAPPED: assert property (@(posedge clk_i) disable iff (srst_i)
    re_i && (addr_i != wdog_pkg::CTRL_OFS) && (addr_i != wdog_pkg::STATUS_OFS)
    |=> rdata_o == '0)
    else $error("unmapped read returned data");

  AST_RDATA_CTRL: assert property (@(posedge clk_i) disable iff (srst_i)
    re_i && (addr_i == wdog_pkg::CTRL_OFS)
    |=> rdata_o[wdog_pkg::CTRL_EN_BIT] == $past(q.cfg.enable))
    else $error("settings read did not show the enable bit");

  AST_RDATA_COUNT: assert property (@(posedge clk_i) disable iff (srst_i)
    re_i && (addr_i == wdog_pkg::STATUS_OFS)
    |=> rdata_o[wdog_pkg::STAT_CNT_LSB +: wdog_pkg::CNT_W] == $past(q.cnt))
    else $error("status read did not show the count");

  AST_RDATA_CAUSE: assert property (@(posedge clk_i) disable iff (srst_i)
    re_i && (addr_i == wdog_pkg::STATUS_OFS)
    |=> rdata_o[wdog_pkg::STAT_EARLY_BIT] == $past(q.early_err)
    && rdata_o[wdog_pkg::STAT_LATE_BIT] == $past(q.late_err))
    else $error("status read did not show the reset cause");

  AST_RDATA_PENDING: assert property (@(posedge clk_i) disable iff (srst_i)
    re_i && (addr_i == wdog_pkg::STATUS_OFS)
    |=> rdata_o[wdog_pkg::STAT_PREST_BIT] == $past(q.pend_restart)
    && rdata_o[wdog_pkg::STAT_PCFG_BIT] == $past(q.pend_cfg_valid))
    else $error("status read did not show the pending flags");

  AST_RDATA_OPEN: assert property (@(posedge clk_i) disable iff (srst_i)
    re_i && (addr_i == wdog_pkg::STATUS_OFS)
    |=> rdata_o[wdog_pkg::STAT_OPEN_BIT] == $past(q.prot == wdog_pkg::PROT_OPEN))
    else $error("status read did not show the write window");

  // the request pin mirrors the state bit so nothing can mask it on the way out
  AST_PIN_MIRROR: assert property (@(posedge clk_i) disable iff (srst_i)
    reset_req_o == q.rst_req)
    else $error("reset request pin differs from its state bit");

  AST_NEW_CFG_ZERO: assert property (@(posedge clk_i) disable iff (srst_i)
    tick_i && q.pend_cfg_valid && q.pend_restart |=> !q.pend_restart)
    else $error("restart kept pending across a settings change");

endmodule

// ### tb/wdog_partner.sv
`timescale 1ns/1ps
module wdog_partner (
  input wire logic clk_i, // system clock
  input wire logic srst_i, // sync reset, active high
  input wire logic [7:0] kick_every_i, // restart every n ticks, 0 for none
  output logic tick_o, // low power tick pulse
  output logic restart_o // restart instruction pulse
);
  logic [2:0] div_q;
  logic [7:0] ticks_q;
  // a tick every 8 clocks stands in for the slow tick so runs stay short
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_q <= 3'h0;
      ticks_q <= 8'h00;
      tick_o <= 1'b0;
      restart_o <= 1'b0;
    end else begin
      div_q <= div_q + 3'h1;
      tick_o <= (div_q == 3'h7);
      // restarts land between ticks, never on the tick cycle itself
      restart_o <= (div_q == 3'h3) && (kick_every_i != 8'h00) &&
        (ticks_q == kick_every_i - 8'h01);
      if (kick_every_i == 8'h00) begin
        ticks_q <= 8'h00;
      end else if (tick_o) begin
        ticks_q <= (ticks_q == kick_every_i - 8'h01) ? 8'h00 : ticks_q + 8'h01;
      end
    end
  end
endmodule

// ### tb/tb_windowed_watchdog_timer.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD %0t got %0h exp %0h", $time, a, b); end end
module tb_windowed_watchdog_timer;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic lock_fuse_i = 1'b0;
  logic [wdog_pkg::ADDR_W-1:0] addr_i = 4'h0;
  logic [wdog_pkg::DATA_W-1:0] wdata_i = 32'h0000_0000;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic [7:0] kick = 8'h00;
  logic [wdog_pkg::DATA_W-1:0] rdata_o;
  logic [wdog_pkg::DATA_W-1:0] d;
  logic reset_req_o;
  logic tick_i;
  logic restart_i;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2 clk_i = ~clk_i;
  windowed_watchdog_timer dut (.clk_i(clk_i), .srst_i(srst_i), .tick_i(tick_i),
    .restart_i(restart_i), .lock_fuse_i(lock_fuse_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .reset_req_o(reset_req_o));
  wdog_partner core (.clk_i(clk_i), .srst_i(srst_i), .kick_every_i(kick), .tick_o(tick_i),
    .restart_o(restart_i));
  task automatic final_report();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic rst();
    srst_i <= 1'b1;
    kick <= 8'h00;
    lock_fuse_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // waits for the edge that takes the n-th tick, then lets its updates land
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i);
      while (tick_i !== 1'b1) @(posedge clk_i);
    end
    repeat (2) @(posedge clk_i);
  endtask
  task automatic cfg(input logic [31:0] v);
    wr(wdog_pkg::PROT_OFS, wdog_pkg::PROT_KEY);
    wr(wdog_pkg::CTRL_OFS, v);
    ticks(1);
  endtask
  task automatic t_guard();
    rst();
    wr(wdog_pkg::CTRL_OFS, 32'h0000_0001);
    ticks(1);
    rd(wdog_pkg::CTRL_OFS);
    `CHK(d, 32'h0000_0000)
    rd(wdog_pkg::PROT_OFS);
    `CHK(d, 32'h0000_0000)
    rd(4'hc);
    `CHK(d, 32'h0000_0000)
    lock_fuse_i <= 1'b1;
    cfg(32'h0000_0001);
    rd(wdog_pkg::CTRL_OFS);
    `CHK(d, 32'h0000_0000)
    ticks(12);
    `CHK(reset_req_o, 1'b0)
  endtask
  task automatic t_codes();
    rst();
    cfg(32'h0000_00a1);
    rd(wdog_pkg::CTRL_OFS);
    `CHK(d, 32'h0000_00a1)
    cfg(32'h0000_00b1);
    rd(wdog_pkg::CTRL_OFS);
    `CHK(d, 32'h0000_00a1)
    cfg(32'h0000_0113);
    rd(wdog_pkg::CTRL_OFS);
    `CHK(d, 32'h0000_00a1)
  endtask
  task automatic t_timeout();
    rst();
    cfg(32'h0000_0001);
    ticks(6);
    `CHK(reset_req_o, 1'b0)
    ticks(4);
    `CHK(reset_req_o, 1'b1)
    rd(wdog_pkg::STATUS_OFS);
    `CHK(d[wdog_pkg::STAT_LATE_BIT], 1'b1)
    ticks(3);
    `CHK(reset_req_o, 1'b1)
  endtask
  task automatic t_kick();
    rst();
    cfg(32'h0000_0001);
    kick <= 8'h04;
    ticks(40);
    `CHK(reset_req_o, 1'b0)
    rd(wdog_pkg::STATUS_OFS);
    `CHK(d[13:3], 11'h000)
  endtask
  task automatic t_window(input logic [7:0] k, input logic exp);
    rst();
    cfg(32'h0000_0023);
    kick <= k;
    ticks(70);
    `CHK(reset_req_o, exp)
    rd(wdog_pkg::STATUS_OFS);
    `CHK(d[wdog_pkg::STAT_EARLY_BIT], exp)
  endtask
  initial begin
    t_guard();
    t_codes();
    t_timeout();
    t_kick();
    t_window(8'h01, 1'b1);
    t_window(8'h10, 1'b0);
    final_report();
  end
endmodule
